// ### eqc_pkg.sv
/*
  package for the equalizer coefficient register bank: offsets, field
  layout, reset values, the unmapped read value and the carrier struct.
  assumes a 32-bit classic wishbone slave with byte addressing.
*/
package eqc_pkg;

  // ------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [11:0] EQC_IDX_TAP0   = 12'h418;  // free index picked for tap zero
  localparam logic [11:0] EQC_IDX_TAP1   = 12'h41a;
  localparam logic [11:0] EQC_IDX_TAP2   = 12'h41c;
  localparam logic [11:0] EQC_IDX_TAP3   = 12'h41e;
  localparam logic [11:0] EQC_IDX_TAP4   = 12'h420;
  localparam logic [11:0] EQC_IDX_MODE   = 12'h400;  // chosen: channel mode select

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int          EQC_SIDE_W     = 12;       // side tap coefficient width
  localparam int          EQC_SIDE_REG_W = 16;       // side tap register width
  localparam int          EQC_CTR_W      = 18;       // center tap coefficient width
  localparam int          EQC_CTR_REG_W  = 24;       // center tap register width
  localparam logic [15:0] EQC_SIDE_RST   = 16'h0000;
  localparam logic [23:0] EQC_CTR_RST    = 24'h000000;
  localparam logic        EQC_MODE_RST   = 1'h0;     // 0 = dual channel
  localparam logic [31:0] EQC_UNMAPPED   = 32'h00000000;

  // five taps held in this bank, center is the last of them
  localparam int          EQC_NTAPS      = 5;

  // ------------------------------------------------------------
  // carrier: coefficients handed to the filter datapaths
  // ------------------------------------------------------------
  typedef struct packed {
    logic signed [17:0] tap4;   // center tap, 18-bit signed
    logic signed [11:0] tap3;
    logic signed [11:0] tap2;
    logic signed [11:0] tap1;
    logic signed [11:0] tap0;
  } eqc_coeff_type;

endpackage

// ### eqc_reg.sv
/*
  one read/write register with byte-lane write enables.
  assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module eqc_reg
  import eqc_pkg::*;
#(
  parameter int          WIDTH = 16,
  parameter logic [31:0] RST   = 32'h00000000
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // write side
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_sel,
  input  wire logic [31:0]      wr_data,
  // stored value
  output logic      [WIDTH-1:0] value
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // the write bus is 32 bits wide, so a wider register could never be filled
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("eqc_reg width out of range");
  end

  // one process owns the whole word; each bit follows its byte lane
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= RST[WIDTH-1:0];
    end else if (wr_en) begin
      for (int b = 0; b < WIDTH; b++) begin
        if (wr_sel[b/8]) begin
          value[b] <= wr_data[b];
        end
      end
    end
  end

endmodule

// ### eqc_coeff_regs.sv
/*
  equalizer fir coefficient register bank, taps zero to four (channel a
  or the shared filter). software reaches it over classic wishbone.
  assumes the filter datapath sits outside and reads coeff_a / coeff_shared.
*/
// Implementation choice: register access over Wishbone.
// Function
// - side tap fields 11:0 are signed two's complement
// - dual mode feeds channel a, single feeds shared
// - tap zero register is first tap, resets zero
// - second tap at 0x41a, rw, resets zero
// - third tap at 0x41c, rw, resets zero
// - fourth tap at 0x41e, rw, resets zero
// - fifth tap at 0x420, 24 bits, resets zero
// - fifth tap is center, 18-bit signed field
`timescale 1ns/1ns
module eqc_coeff_regs
  import eqc_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // coefficients to the filters
  output eqc_coeff_type      coeff_a,
  output eqc_coeff_type      coeff_shared,
  output logic               single_mode
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // the word index is cut from bits 13:2, so a narrower bus misses the map
  if (ADDR_W < 14) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        req;        // live request with no ack yet given
  logic [11:0] idx;        // word index of the access
  logic        wr_go;      // write strobe, one cycle, the one before the ack
  logic [15:0] tap0;       // side tap registers
  logic [15:0] tap1;
  logic [15:0] tap2;
  logic [15:0] tap3;
  logic [23:0] tap4;       // center tap register
  logic        mode;       // 1 = single channel
  logic [31:0] next_rdata; // read mux

  // ack is registered so the master sees one wait state; not acking
  // twice in a row keeps a held request from writing twice
  // one access, edges counted from the one at which stb is first seen:
  //   edge 1: request taken, register written, ack rises
  //   edge 2: master samples ack, takes read data, drops stb
  //   edge 2 also: ack low again, the bus is free for the next request
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx   = wb_adr_i[13:2];
  assign wr_go = req && wb_we_i;

  // ack the cycle after the request, drop it the cycle after
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // upper reserved bits are stored too, since they are read/write
  // tap zero: first filter tap
  eqc_reg #(
    .WIDTH (EQC_SIDE_REG_W),
    .RST   ({16'h0000, EQC_SIDE_RST})
  ) u_tap0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_go && idx == EQC_IDX_TAP0),
    .wr_sel  (wb_sel_i),
    .wr_data (wb_dat_i),
    .value   (tap0)
  );
  // tap one: second filter tap
  eqc_reg #(
    .WIDTH (EQC_SIDE_REG_W),
    .RST   ({16'h0000, EQC_SIDE_RST})
  ) u_tap1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_go && idx == EQC_IDX_TAP1),
    .wr_sel  (wb_sel_i),
    .wr_data (wb_dat_i),
    .value   (tap1)
  );
  // tap two: third filter tap
  eqc_reg #(
    .WIDTH (EQC_SIDE_REG_W),
    .RST   ({16'h0000, EQC_SIDE_RST})
  ) u_tap2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_go && idx == EQC_IDX_TAP2),
    .wr_sel  (wb_sel_i),
    .wr_data (wb_dat_i),
    .value   (tap2)
  );
  // tap three: fourth filter tap
  eqc_reg #(
    .WIDTH (EQC_SIDE_REG_W),
    .RST   ({16'h0000, EQC_SIDE_RST})
  ) u_tap3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_go && idx == EQC_IDX_TAP3),
    .wr_sel  (wb_sel_i),
    .wr_data (wb_dat_i),
    .value   (tap3)
  );
  // tap four: center tap, the one 24-bit register of the bank
  eqc_reg #(
    .WIDTH (EQC_CTR_REG_W),
    .RST   ({8'h00, EQC_CTR_RST})
  ) u_tap4 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_go && idx == EQC_IDX_TAP4),
    .wr_sel  (wb_sel_i),
    .wr_data (wb_dat_i),
    .value   (tap4)
  );

  // channel mode select, bit 0 of the mode register
  // only bit 0 is stored; the rest of that word reads zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= EQC_MODE_RST;
    end else if (wr_go && idx == EQC_IDX_MODE && wb_sel_i[0]) begin
      mode <= wb_dat_i[0];
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // plain mux on the index; registered below so wb_dat_o is a flop
  always_comb begin
    case (idx)
      EQC_IDX_TAP0: next_rdata = {16'h0000, tap0};
      EQC_IDX_TAP1: next_rdata = {16'h0000, tap1};
      EQC_IDX_TAP2: next_rdata = {16'h0000, tap2};
      EQC_IDX_TAP3: next_rdata = {16'h0000, tap3};
      EQC_IDX_TAP4: next_rdata = {8'h00, tap4};
      EQC_IDX_MODE: next_rdata = {31'h00000000, mode};
      default:      next_rdata = EQC_UNMAPPED; // unmapped reads zero, writes dropped
    endcase
  end

  // read data registered alongside the ack
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // coefficient routing to the filters
  // ------------------------------------------------------------
  eqc_coeff_type next_coeff; // fields cut out of the registers

  // only the coefficient fields go on; reserved bits stay in the bank
  always_comb begin
    next_coeff.tap0 = $signed(tap0[EQC_SIDE_W-1:0]);
    next_coeff.tap1 = $signed(tap1[EQC_SIDE_W-1:0]);
    next_coeff.tap2 = $signed(tap2[EQC_SIDE_W-1:0]);
    next_coeff.tap3 = $signed(tap3[EQC_SIDE_W-1:0]);
    next_coeff.tap4 = $signed(tap4[EQC_CTR_W-1:0]);
  end

  // the unused destination sees zeros so a stale set never leaks in
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coeff_a      <= '0;
      coeff_shared <= '0;
      single_mode  <= EQC_MODE_RST;
    end else begin
      single_mode  <= mode;
      coeff_a      <= mode ? '0 : next_coeff;
      coeff_shared <= mode ? next_coeff : '0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // a full-word write taken at a given index
  sequence s_write(logic [11:0] i);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && idx == i && (&wb_sel_i);
  endsequence

  // a read taken at a given index
  sequence s_read(logic [11:0] i);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && idx == i;
  endsequence

  // the single answer that follows a taken request
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  chk_ack_follows_req: assert property (@(posedge clk) disable iff (sys_rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");

  chk_tap0_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_write(EQC_IDX_TAP0) |=> tap0 == $past(wb_dat_i[15:0]))
    else $error("tap0 write lost");

  chk_tap1_read: assert property (@(posedge clk) disable iff (sys_rst)
    (req && !wb_we_i && idx == EQC_IDX_TAP1) |=> wb_dat_o == {16'h0000, $past(tap1)})
    else $error("tap1 readback wrong");

  chk_tap4_width: assert property (@(posedge clk) disable iff (sys_rst)
    s_write(EQC_IDX_TAP4) |=> tap4 == $past(wb_dat_i[23:0]))
    else $error("tap4 write wrong");

  chk_center_sign: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_a.tap4 == $past(tap4[17:0])) else $error("center tap wrong");

  chk_side_sign: assert property (@(posedge clk) disable iff (sys_rst)
    mode |=> coeff_shared.tap2 == $past(tap2[11:0])) else $error("side tap wrong");

  chk_mode_route: assert property (@(posedge clk) disable iff (sys_rst)
    mode |=> coeff_a == '0 && single_mode) else $error("channel a not idle");

  chk_tap3_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_write(EQC_IDX_TAP3) |=> ##1 wb_ack_o == 1'b0 && tap3 == $past(wb_dat_i[15:0], 2))
    else $error("tap3 write lost");

  chk_single_answer: assert property (@(posedge clk) disable iff (sys_rst)
    req |=> s_answer)
    else $error("ack not a single pulse");

  chk_tap1_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_write(EQC_IDX_TAP1) |=> tap1 == $past(wb_dat_i[15:0]))
    else $error("tap1 write lost");

  chk_tap2_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_write(EQC_IDX_TAP2) |=> tap2 == $past(wb_dat_i[15:0]))
    else $error("tap2 write lost");

  chk_lane_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_go && idx == EQC_IDX_TAP1 && !wb_sel_i[0]) |=> tap1[7:0] == $past(tap1[7:0]))
    else $error("unselected lane changed");

  chk_tap0_read: assert property (@(posedge clk) disable iff (sys_rst)
    s_read(EQC_IDX_TAP0) |=> wb_dat_o == {16'h0000, $past(tap0)})
    else $error("tap0 readback wrong");

  chk_center_read: assert property (@(posedge clk) disable iff (sys_rst)
    s_read(EQC_IDX_TAP4) |=> wb_dat_o == {8'h00, $past(tap4)})
    else $error("tap4 readback wrong");

  chk_shared_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_shared == '0 && !single_mode)
    else $error("shared filter not idle");

  chk_center_shared: assert property (@(posedge clk) disable iff (sys_rst)
    mode |=> coeff_shared.tap4 == $past(tap4[17:0]))
    else $error("shared center tap wrong");

  chk_tap0_route: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_a.tap0 == $past(tap0[11:0]))
    else $error("first tap not routed");

  chk_tap1_route: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_a.tap1 == $past(tap1[11:0]))
    else $error("second tap not routed");

  chk_tap2_route: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_a.tap2 == $past(tap2[11:0]))
    else $error("third tap not routed");

  chk_tap3_route: assert property (@(posedge clk) disable iff (sys_rst)
    !mode |=> coeff_a.tap3 == $past(tap3[11:0]))
    else $error("fourth tap not routed");

  chk_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_go && idx == EQC_IDX_MODE && wb_sel_i[0]) |=> mode == $past(wb_dat_i[0]))
    else $error("mode write lost");

endmodule

// ### eqc_tb.sv
/*
  self-checking bench for the equalizer coefficient register bank.
  assumes one 20 MHz clock, a classic wishbone master in this file and
  the design's own in-line assertions watching its logic.
*/
`timescale 1ns/1ns
// compare one value, count it, report a mismatch at once
`define EQC_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
  import eqc_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic          clk, sys_rst;               // clock and async reset
  logic          cyc, stb, we;               // wishbone request
  logic [13:0]   adr;                        // byte address
  logic [3:0]    sel;                        // byte lanes
  logic [31:0]   dat_w, dat_r;               // write data, read data
  logic          ack;                        // one-cycle answer
  eqc_coeff_type coeff_a, coeff_shared;      // filter coefficients
  logic          single_mode;                // channel mode copy
  int            err_count, n_compared;      // tallies
  logic [31:0]   rd;                         // last read value
  eqc_coeff_type exp_c;                      // expected coefficient set
  logic [11:0]   idx [5] = '{EQC_IDX_TAP0, EQC_IDX_TAP1, EQC_IDX_TAP2, EQC_IDX_TAP3,
                             EQC_IDX_TAP4};
  logic [31:0]   pat [5] = '{32'hfedcb9a0, 32'hfedcb9a1, 32'hfedcb9a2, 32'hfedcb9a3,
                             32'hfedcb9a4};

  eqc_coeff_regs DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .coeff_a(coeff_a), .coeff_shared(coeff_shared),
    .single_mode(single_mode));

  // ------------------------------------------------------------
  // clock, reset and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a whole run needs well under a thousand cycles; this cuts a hang
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // bus cycle: raised after an edge, held until the edge that samples ack
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [11:0] i, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {i, 2'b00};
    sel   <= s;
    dat_w <= d;
    // code woken by the edge still reads the values from before it, so ack
    // and read data are taken just as the edge samples them; a hang is cut
    // by the watchdog alone
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // every tap, channel a and the mode copy read zero straight after reset
  task automatic t_reset_values();
    for (int k = 0; k < 5; k++) begin
      wb(1'b0, idx[k], 4'hf, 32'h0);
      `EQC_CHK(rd, 32'h00000000)
    end
    `EQC_CHK(coeff_a, '0)
    `EQC_CHK(single_mode, 1'b0)
  endtask

  // full writes: stored width limits readback, fields reach channel a
  task automatic t_write_taps();
    for (int k = 0; k < 5; k++) wb(1'b1, idx[k], 4'hf, pat[k]);
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, idx[k], 4'hf, 32'h0);
      `EQC_CHK(rd, {16'h0000, pat[k][15:0]})
    end
    wb(1'b0, idx[4], 4'hf, 32'h0);
    `EQC_CHK(rd, {8'h00, pat[4][23:0]})
    exp_c = {pat[4][17:0], pat[3][11:0], pat[2][11:0], pat[1][11:0], pat[0][11:0]};
    @(negedge clk);
    `EQC_CHK(coeff_a, exp_c)
    `EQC_CHK($signed(coeff_a.tap0) < 0, 1'b1)
    `EQC_CHK(coeff_shared, '0)
  endtask

  // single lane write alters only its byte; unmapped place reads zero
  task automatic t_lanes_unmapped();
    wb(1'b1, EQC_IDX_TAP1, 4'b0010, 32'h00001200);
    wb(1'b0, EQC_IDX_TAP1, 4'hf, 32'h0);
    `EQC_CHK(rd, 32'h000012a1)
    wb(1'b1, 12'h419, 4'hf, 32'hffffffff);
    wb(1'b0, 12'h419, 4'hf, 32'h0);
    `EQC_CHK(rd, EQC_UNMAPPED)
    wb(1'b0, EQC_IDX_TAP0, 4'hf, 32'h0);
    `EQC_CHK(rd, {16'h0000, pat[0][15:0]})
  endtask

  // single channel mode moves the set to the shared filter
  task automatic t_single_mode();
    wb(1'b1, EQC_IDX_MODE, 4'hf, 32'h00000001);
    @(negedge clk);
    exp_c.tap1 = 12'h2a1;
    `EQC_CHK(single_mode, 1'b1)
    `EQC_CHK(coeff_shared, exp_c)
    `EQC_CHK(coeff_a, '0)
    // the mode word reads back, and dual mode hands the set to channel a
    wb(1'b0, EQC_IDX_MODE, 4'hf, 32'h0);
    `EQC_CHK(rd, 32'h00000001)
    wb(1'b1, EQC_IDX_MODE, 4'hf, 32'h00000000);
    @(negedge clk);
    `EQC_CHK(single_mode, 1'b0)
    `EQC_CHK(coeff_a, exp_c)
    `EQC_CHK(coeff_shared, '0)
  endtask

  // a reset in mid-run clears the bank again
  task automatic t_second_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wb(1'b0, EQC_IDX_TAP4, 4'hf, 32'h0);
    `EQC_CHK(rd, 32'h00000000)
    `EQC_CHK(coeff_shared, '0)
    `EQC_CHK(coeff_a, '0)
  endtask

  // ------------------------------------------------------------
  // verdict, the only place the run ends
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial begin
    err_count  = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    cyc        = 1'b0;
    stb        = 1'b0;
    we         = 1'b0;
    adr        = '0;
    sel        = '0;
    dat_w      = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_write_taps();
    t_lanes_unmapped();
    t_single_mode();
    t_second_reset();
    report_and_stop();
  end
endmodule
